// ### hdl/dwarm_pkg.sv
// shared constants and carrier types for the dma width/align/request-map
// block; assumes one 50 MHz system clock and synchronous reset
package dwarm_pkg;
  localparam int NUM_CHANNELS = 8;
  localparam int COUNT_W      = 16;
  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int NUM_PERIPH_REQ = 25;

  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;

  // access width encodings
  localparam logic [1:0] WIDTH_8   = 2'h0;
  localparam logic [1:0] WIDTH_16  = 2'h1;
  localparam logic [1:0] WIDTH_32  = 2'h2;
  localparam logic [1:0] WIDTH_RSV = 2'h3;

  // peripheral request line positions
  localparam int REQ_CONVERTER     = 0;
  localparam int REQ_SPI_RX        = 1;
  localparam int REQ_SPI_TX        = 2;
  localparam int REQ_SP1_TX        = 3;
  localparam int REQ_SP1_RX        = 4;
  localparam int REQ_SP2_RX        = 5;
  localparam int REQ_SP2_TX        = 6;
  localparam int REQ_SP3_TX        = 7;
  localparam int REQ_SP3_RX        = 8;
  localparam int REQ_SP4_TX        = 9;
  localparam int REQ_SP4_RX        = 10;
  localparam int REQ_I2C_TX        = 11;
  localparam int REQ_I2C_RX        = 12;
  localparam int REQ_ADV_CAP1      = 13;
  localparam int REQ_ADV_CAP2      = 14;
  localparam int REQ_ADV_CAP3      = 15;
  localparam int REQ_ADV_CAP4      = 16;
  localparam int REQ_ADV_TRIG_COM  = 17;
  localparam int REQ_ADV_RELOAD    = 18;
  localparam int REQ_GEN_CAP1      = 19;
  localparam int REQ_GEN_CAP2      = 20;
  localparam int REQ_GEN_CAP3      = 21;
  localparam int REQ_GEN_CAP4      = 22;
  localparam int REQ_GEN_TRIG_COM  = 23;
  // reload has a line of its own so it never leaks onto channel 7
  localparam int REQ_GEN_RELOAD    = 24;

  // per-channel settings as software programs them
  typedef struct packed {
    logic        enable;
    logic        periph_addr_step_on;
    logic        mem_addr_step_on;
    logic [1:0]  periph_access_width;
    logic [1:0]  mem_access_width;
    logic        mem_to_periph;
  } dwarm_config_t;

  // one data beat on the bus
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  width;
  } dwarm_beat_t;
endpackage

// ### hdl/dwarm_req_map.sv
// fixed routing of peripheral request lines onto the eight channels
// assumes request lines are already synchronous to sys_clk
`timescale 1ns/1ps
module dwarm_req_map (
  input  wire logic [dwarm_pkg::NUM_PERIPH_REQ-1:0] periph_req,
  output logic      [dwarm_pkg::NUM_CHANNELS-1:0]   chan_req
);
  always_comb begin
    // several peripherals are or-ed onto each channel
    chan_req[0] = periph_req[dwarm_pkg::REQ_CONVERTER]
                | periph_req[dwarm_pkg::REQ_SP4_TX]
                | periph_req[dwarm_pkg::REQ_GEN_CAP3];
    chan_req[1] = periph_req[dwarm_pkg::REQ_SPI_RX]
                | periph_req[dwarm_pkg::REQ_SP3_TX]
                | periph_req[dwarm_pkg::REQ_ADV_CAP1]
                | periph_req[dwarm_pkg::REQ_GEN_RELOAD];
    chan_req[2] = periph_req[dwarm_pkg::REQ_SPI_TX]
                | periph_req[dwarm_pkg::REQ_SP3_RX]
                | periph_req[dwarm_pkg::REQ_ADV_CAP2];
    chan_req[3] = periph_req[dwarm_pkg::REQ_SP1_TX]
                | periph_req[dwarm_pkg::REQ_ADV_CAP4]
                | periph_req[dwarm_pkg::REQ_ADV_TRIG_COM];
    chan_req[4] = periph_req[dwarm_pkg::REQ_SP1_RX]
                | periph_req[dwarm_pkg::REQ_ADV_RELOAD]
                | periph_req[dwarm_pkg::REQ_GEN_CAP1];
    chan_req[5] = periph_req[dwarm_pkg::REQ_SP2_RX]
                | periph_req[dwarm_pkg::REQ_I2C_TX]
                | periph_req[dwarm_pkg::REQ_ADV_CAP3];
    chan_req[6] = periph_req[dwarm_pkg::REQ_SP2_TX]
                | periph_req[dwarm_pkg::REQ_I2C_RX]
                | periph_req[dwarm_pkg::REQ_GEN_CAP2]
                | periph_req[dwarm_pkg::REQ_GEN_CAP4];
    chan_req[7] = periph_req[dwarm_pkg::REQ_SP4_RX]
                | periph_req[dwarm_pkg::REQ_GEN_TRIG_COM];
  end
endmodule

// ### hdl/dwarm_top.sv
// per-channel data path of an eight-channel dma: counts, addresses,
// width conversion and request routing. assumes one memory-style bus
// answering each read/write with a one-cycle done pulse; software bits
// arrive as plain ports synchronous to sys_clk.
`timescale 1ns/1ps
module dwarm_top #(
  parameter int NCH = dwarm_pkg::NUM_CHANNELS
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  sys_rst,
  input  wire logic [dwarm_pkg::NUM_PERIPH_REQ-1:0]  periph_req,
  input  wire dwarm_pkg::dwarm_config_t [NCH-1:0]    channel_config,
  input  wire logic [NCH-1:0]                        count_wr,
  input  wire logic [15:0]                           count_wdata,
  input  wire logic [NCH-1:0]                        periph_start_wr,
  input  wire logic [NCH-1:0]                        mem_start_wr,
  input  wire logic [31:0]                           addr_wdata,
  input  wire logic [2:0]                            count_rsel,
  input  wire logic                                  bus_done,
  input  wire logic [31:0]                           bus_rdata,
  output logic [15:0]                                transfer_count,
  output logic                                       bus_rd,
  output logic                                       bus_wr,
  output dwarm_pkg::dwarm_beat_t                     bus_beat,
  output logic                                       width_error
);
  typedef enum logic [2:0] {
    DWARM_IDLE  = 3'b001,
    DWARM_READ  = 3'b010,
    DWARM_WRITE = 3'b100
  } dwarm_state_t;

  // bytes per beat; reserved code maps to 0 and raises width_error
  function automatic logic [2:0] dwarm_bytes(input logic [1:0] w);
    unique case (w)
      dwarm_pkg::WIDTH_8:  dwarm_bytes = 3'h1;
      dwarm_pkg::WIDTH_16: dwarm_bytes = 3'h2;
      dwarm_pkg::WIDTH_32: dwarm_bytes = 3'h4;
      default:             dwarm_bytes = 3'h0;
    endcase
  endfunction

  // keep the low part, zero the rest, lsb at lowest address
  function automatic logic [31:0] dwarm_fit(input logic [31:0] d,
                                            input logic [1:0] w);
    unique case (w)
      dwarm_pkg::WIDTH_8:  dwarm_fit = {24'h000000, d[7:0]};
      dwarm_pkg::WIDTH_16: dwarm_fit = {16'h0000, d[15:0]};
      default:             dwarm_fit = d;
    endcase
  endfunction

  logic [NCH-1:0] chan_req;
  logic [15:0] count_reg [NCH];
  logic [15:0] count_next [NCH];
  logic [31:0] paddr_start_reg [NCH];
  logic [31:0] paddr_start_next [NCH];
  logic [31:0] maddr_start_reg [NCH];
  logic [31:0] maddr_start_next [NCH];
  logic [31:0] pcur_reg [NCH];
  logic [31:0] pcur_next [NCH];
  logic [31:0] mcur_reg [NCH];
  logic [31:0] mcur_next [NCH];
  logic [NCH-1:0] run_reg;
  logic [NCH-1:0] run_next;
  dwarm_state_t state_reg;
  dwarm_state_t state_next;
  logic [2:0] chan_reg;
  logic [2:0] chan_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic [15:0] tcount_next;
  logic bus_rd_next;
  logic bus_wr_next;
  dwarm_pkg::dwarm_beat_t beat_next;
  logic werr_reg;
  logic werr_next;
  logic [2:0] pick;
  logic pick_ok;
  dwarm_pkg::dwarm_config_t cc;

  dwarm_req_map u_map (
    .periph_req (periph_req),
    .chan_req   (chan_req)
  );

  // lowest channel number wins; full arbitration lives elsewhere
  always_comb begin
    pick = 3'h0;
    pick_ok = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (run_reg[i] && chan_req[i] && count_reg[i] != 16'h0000) begin
        pick = i[2:0];
        pick_ok = 1'b1;
      end
    end
  end

  always_comb begin
    cc = channel_config[chan_reg];
    state_next = state_reg;
    chan_next = chan_reg;
    data_next = data_reg;
    bus_rd_next = 1'b0;
    bus_wr_next = 1'b0;
    beat_next = bus_beat;
    werr_next = 1'b0;
    run_next = run_reg;
    for (int i = 0; i < NCH; i++) begin
      count_next[i] = count_reg[i];
      paddr_start_next[i] = paddr_start_reg[i];
      maddr_start_next[i] = maddr_start_reg[i];
      pcur_next[i] = pcur_reg[i];
      mcur_next[i] = mcur_reg[i];
      run_next[i] = channel_config[i].enable;
      if (!channel_config[i].enable) begin
        // writes only while off; while on they are dropped
        if (count_wr[i])
          count_next[i] = count_wdata;
        if (periph_start_wr[i])
          paddr_start_next[i] = addr_wdata;
        if (mem_start_wr[i])
          maddr_start_next[i] = addr_wdata;
        // first beat starts at the programmed addresses
        pcur_next[i] = paddr_start_next[i];
        mcur_next[i] = maddr_start_next[i];
      end
    end
    unique case (state_reg)
      DWARM_IDLE: begin
        if (pick_ok) begin
          chan_next = pick;
          cc = channel_config[pick];
          if (dwarm_bytes(cc.periph_access_width) == 3'h0 ||
              dwarm_bytes(cc.mem_access_width) == 3'h0) begin
            werr_next = 1'b1;
          end else begin
            state_next = DWARM_READ;
            bus_rd_next = 1'b1;
            beat_next.addr = cc.mem_to_periph ? mcur_reg[pick]
                                              : pcur_reg[pick];
            beat_next.width = cc.mem_to_periph ? cc.mem_access_width
                                               : cc.periph_access_width;
            beat_next.data = 32'h0000_0000;
          end
        end
      end
      DWARM_READ: begin
        bus_rd_next = !bus_done;
        if (bus_done) begin
          data_next = dwarm_fit(bus_rdata, beat_next.width);
          state_next = DWARM_WRITE;
          bus_wr_next = 1'b1;
          beat_next.addr = cc.mem_to_periph ? pcur_reg[chan_reg]
                                            : mcur_reg[chan_reg];
          beat_next.width = cc.mem_to_periph ? cc.periph_access_width
                                             : cc.mem_access_width;
          // narrow to the destination width
          beat_next.data = dwarm_fit(data_next, beat_next.width);
        end
      end
      DWARM_WRITE: begin
        bus_wr_next = !bus_done;
        if (bus_done) begin
          state_next = DWARM_IDLE;
          // one decrement per completed beat
          count_next[chan_reg] = count_reg[chan_reg] - 16'h0001;
          // steps follow each side's own width
          if (cc.periph_addr_step_on)
            pcur_next[chan_reg] = pcur_reg[chan_reg]
              + {29'h0, dwarm_bytes(cc.periph_access_width)};
          if (cc.mem_addr_step_on)
            mcur_next[chan_reg] = mcur_reg[chan_reg]
              + {29'h0, dwarm_bytes(cc.mem_access_width)};
        end
      end
      default: state_next = DWARM_IDLE;
    endcase
    tcount_next = count_next[count_rsel];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= DWARM_IDLE;
      chan_reg <= 3'h0;
      data_reg <= 32'h0000_0000;
      run_reg <= '0;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_beat <= '0;
      werr_reg <= 1'b0;
      transfer_count <= dwarm_pkg::COUNT_RESET;
      for (int i = 0; i < NCH; i++) begin
        count_reg[i] <= dwarm_pkg::COUNT_RESET;
        paddr_start_reg[i] <= dwarm_pkg::ADDR_RESET;
        maddr_start_reg[i] <= dwarm_pkg::ADDR_RESET;
        pcur_reg[i] <= dwarm_pkg::ADDR_RESET;
        mcur_reg[i] <= dwarm_pkg::ADDR_RESET;
      end
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      data_reg <= data_next;
      run_reg <= run_next;
      bus_rd <= bus_rd_next;
      bus_wr <= bus_wr_next;
      bus_beat <= beat_next;
      werr_reg <= werr_next;
      transfer_count <= tcount_next;
      for (int i = 0; i < NCH; i++) begin
        count_reg[i] <= count_next[i];
        paddr_start_reg[i] <= paddr_start_next[i];
        maddr_start_reg[i] <= maddr_start_next[i];
        pcur_reg[i] <= pcur_next[i];
        mcur_reg[i] <= mcur_next[i];
      end
    end
  end

  assign width_error = werr_reg;

  a_count_locked: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (channel_config[0].enable && $past(channel_config[0].enable)
     && state_reg != DWARM_WRITE) |=> $stable(count_reg[0]))
    else $error("count changed while channel running");
  a_count_dec: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state_reg == DWARM_WRITE && bus_done) |=>
    count_reg[$past(chan_reg)] == $past(count_reg[chan_reg]) - 16'h0001)
    else $error("count not decremented by one");
  a_read_follows: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state_reg == DWARM_READ && bus_done) |=> bus_wr)
    else $error("write did not follow read");
  a_dest_zero_ext: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (bus_wr && bus_beat.width == dwarm_pkg::WIDTH_8) |->
    bus_beat.data[31:8] == 24'h000000)
    else $error("upper bits not zero on byte write");
  a_half_zero_ext: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (bus_wr && bus_beat.width == dwarm_pkg::WIDTH_16) |->
    bus_beat.data[31:16] == 16'h0000)
    else $error("upper bits not zero on half write");
  a_no_rsv_width: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (bus_rd || bus_wr) |-> bus_beat.width != dwarm_pkg::WIDTH_RSV)
    else $error("reserved width on bus");
  a_mem_fixed: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state_reg == DWARM_WRITE && bus_done
     && !channel_config[chan_reg].mem_addr_step_on
     && channel_config[chan_reg].enable) |=>
    mcur_reg[$past(chan_reg)] == $past(mcur_reg[chan_reg]))
    else $error("memory address moved without increment");
  a_periph_step: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state_reg == DWARM_WRITE && bus_done
     && channel_config[chan_reg].periph_addr_step_on
     && channel_config[chan_reg].enable) |=>
    pcur_reg[$past(chan_reg)] == $past(pcur_reg[chan_reg])
      + {29'h0, dwarm_bytes($past(cc.periph_access_width))})
    else $error("peripheral step wrong");
endmodule

// ### bench/dwarm_mem_model.sv
// byte-wide memory and peripheral space behind the dma bus
// assumes bus_rd/bus_wr stand until the cycle after bus_done
`timescale 1ns/1ps
module dwarm_mem_model (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   bus_rd,
  input  wire logic                   bus_wr,
  input  wire dwarm_pkg::dwarm_beat_t bus_beat,
  input  wire logic                   slow,
  output logic                        bus_done,
  output logic [31:0]                 bus_rdata
);
  logic [7:0]  mem [0:4095];
  logic [11:0] a;
  int          nb;
  int          wait_cnt;
  always @(posedge sys_clk) begin
    a = bus_beat.addr[11:0];
    nb = (bus_beat.width == dwarm_pkg::WIDTH_8) ? 1 :
         (bus_beat.width == dwarm_pkg::WIDTH_16) ? 2 : 4;
    if (sys_rst) begin
      bus_done <= 1'b0;
      wait_cnt <= 0;
      bus_rdata <= 32'h0;
    end else if ((bus_rd || bus_wr) && !bus_done &&
                 wait_cnt >= (slow ? 3 : 0)) begin
      bus_done <= 1'b1;
      wait_cnt <= 0;
      // bytes above the access width read back as the inverted memory byte, not zeroed
      for (int i = 0; i < 4; i++) begin
        if (bus_rd)
          bus_rdata[8*i +: 8] <= (i < nb) ? mem[a + i] : ~mem[a + i];
        if (bus_wr && i < nb)
          mem[a + i] <= bus_beat.data[8*i +: 8];
      end
    end else begin
      bus_done <= 1'b0;
      wait_cnt <= ((bus_rd || bus_wr) && !bus_done) ? wait_cnt + 1 : 0;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule

// ### bench/testbench.sv
// self-checking bench for the dma width/align/request-map data path
// assumes dwarm_mem_model answers the block's memory-style bus
`timescale 1ns/1ps
module testbench;
  logic                           sys_clk;
  logic                           sys_rst;
  logic [dwarm_pkg::NUM_PERIPH_REQ-1:0] periph_req;
  dwarm_pkg::dwarm_config_t [7:0] cfg;
  logic [7:0]                     count_wr;
  logic [15:0]                    count_wdata;
  logic [7:0]                     periph_start_wr;
  logic [7:0]                     mem_start_wr;
  logic [31:0]                    addr_wdata;
  logic [2:0]                     count_rsel;
  logic                           bus_done;
  logic [31:0]                    bus_rdata;
  logic [15:0]                    transfer_count;
  logic                           bus_rd;
  logic                           bus_wr;
  dwarm_pkg::dwarm_beat_t         bus_beat;
  logic                           width_error;
  logic                           slow;
  logic [31:0]                    rda;
  logic [31:0]                    wra;
  logic [1:0]                     ps;
  logic [1:0]                     ms;
  logic                           inc;
  logic                           saw_e;
  logic                           saw_r;
  int                             sb;
  int                             db;
  int                             n_errors;
  int                             num_checks;
  int                             sa;
  int                             da;
  logic [31:0]                    mb;
  int rmap [25] = '{0,1,2,3,4,5,6,1,2,0,7,5,6,1,2,5,3,3,4,4,6,0,6,7,1};
  localparam dwarm_pkg::dwarm_config_t byte_cfg =
    '{1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0};

  dwarm_top dwarm_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .periph_req(periph_req), .channel_config(cfg), .count_wr(count_wr),
    .count_wdata(count_wdata), .periph_start_wr(periph_start_wr),
    .mem_start_wr(mem_start_wr), .addr_wdata(addr_wdata),
    .count_rsel(count_rsel), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .transfer_count(transfer_count), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_beat(bus_beat), .width_error(width_error));
  dwarm_mem_model dwarm_mem_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_beat(bus_beat), .slow(slow),
    .bus_done(bus_done), .bus_rdata(bus_rdata));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // channel must be off while count and start addresses are written
  task automatic setup(int ch, logic [15:0] cnt, logic [31:0] pa,
                       dwarm_pkg::dwarm_config_t c);
    @(posedge sys_clk) cfg[ch].enable <= 1'b0;
    @(posedge sys_clk) begin
      count_wr[ch] <= 1'b1;
      count_wdata <= cnt;
      periph_start_wr[ch] <= 1'b1;
      addr_wdata <= pa;
    end
    @(posedge sys_clk) begin
      count_wr <= 8'h00;
      periph_start_wr <= 8'h00;
      mem_start_wr[ch] <= 1'b1;
      addr_wdata <= 32'h0000_0800;
    end
    @(posedge sys_clk) begin
      mem_start_wr <= 8'h00;
      cfg[ch] <= c;
    end
  endtask

  task automatic chk_count(int ch, logic [15:0] exp);
    @(posedge sys_clk) count_rsel <= ch[2:0];
    repeat (2) @(negedge sys_clk);
    chk({16'h0, transfer_count}, {16'h0, exp}, "count");
  endtask

  // one request, then capture source and destination addresses
  task automatic do_xfer(int idx);
    int n;
    n = 0;
    @(posedge sys_clk) periph_req[idx] <= 1'b1;
    while (bus_rd !== 1'b1 && n++ < 50) @(negedge sys_clk);
    rda = bus_beat.addr;
    @(posedge sys_clk) periph_req[idx] <= 1'b0;
    while (bus_wr !== 1'b1 && n++ < 100) @(negedge sys_clk);
    wra = bus_beat.addr;
    while (bus_wr !== 1'b0 && n++ < 150) @(negedge sys_clk);
    chk(32'(n < 150), 32'h1, "handshake");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    {periph_req, cfg, count_wr, count_wdata} = '0;
    {periph_start_wr, mem_start_wr, addr_wdata, count_rsel} = '0;
    {slow, n_errors, num_checks} = '0;
    sys_rst = 1'b1;
    for (int j = 0; j < 256; j++)
      dwarm_mem_model_i.mem[12'h100 + j] = 8'(8'h40 + j);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // last pass keeps both addresses fixed
    for (int i = 0; i < 10; i++) begin
      inc = (i < 9);
      ps = inc ? 2'(i / 3) : 2'h1;
      ms = inc ? 2'(i % 3) : 2'h1;
      sb = 1 << ps;
      db = 1 << ms;
      for (int j = 0; j < 16; j++) dwarm_mem_model_i.mem[12'h800 + j] = 8'hEE;
      slow <= ps[0];
      setup(0, 16'h0002, 32'h100, '{1'b1, inc, inc, ps, ms, 1'b0});
      for (int k = 0; k < 2; k++) begin
        sa = inc ? k * sb : 0;
        da = inc ? k * db : 0;
        do_xfer(dwarm_pkg::REQ_CONVERTER);
        chk(rda, 32'h100 + sa, "src");
        chk(wra, 32'h800 + da, "dst");
        for (int b = 0; b < db; b++) begin
          mb = 32'(dwarm_mem_model_i.mem[12'h800 + da + b]);
          chk(mb, b < sb ? 32'h40 + sa + b : 0, "byte");
        end
        chk_count(0, 16'(1 - k));
      end
    end
    $display("test widths done");
    setup(1, 16'hFFFF, 32'h110, '{1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0});
    chk_count(1, 16'hFFFF);
    @(posedge sys_clk) begin
      count_wr[1] <= 1'b1;
      count_wdata <= 16'h0003;
    end
    @(posedge sys_clk) count_wr <= 8'h00;
    chk_count(1, 16'hFFFF);
    $display("test count lock done");
    setup(0, 16'h0001, 32'h100, '{1'b1, 1'b1, 1'b1, 2'h3, 2'h0, 1'b0});
    {saw_e, saw_r} = 2'b00;
    @(posedge sys_clk) periph_req[0] <= 1'b1;
    repeat (10) begin
      @(negedge sys_clk);
      saw_e = saw_e | width_error;
      saw_r = saw_r | bus_rd;
    end
    @(posedge sys_clk) periph_req[0] <= 1'b0;
    chk(32'(saw_e), 32'h1, "werr");
    chk(32'(saw_r), 32'h0, "no xfer");
    chk_count(0, 16'h0001);
    $display("test reserved width done");
    // memory to peripheral: byte source widened onto a word destination
    for (int j = 0; j < 4; j++)
      dwarm_mem_model_i.mem[12'h800 + j] = 8'(8'hA0 + j);
    setup(2, 16'h0001, 32'h900, '{1'b1, 1'b1, 1'b1, 2'h2, 2'h0, 1'b1});
    do_xfer(dwarm_pkg::REQ_SPI_TX);
    chk(rda, 32'h800, "m2p src");
    chk(wra, 32'h900, "m2p dst");
    for (int b = 0; b < 4; b++) begin
      mb = 32'(dwarm_mem_model_i.mem[12'h900 + b]);
      chk(mb, b == 0 ? 32'hA0 : 0, "m2p byte");
    end
    chk_count(2, 16'h0000);
    $display("test direction done");
    for (int c = 0; c < 8; c++)
      setup(c, 16'h0001, 32'(32'h100 + c * 16), byte_cfg);
    for (int r = 0; r < dwarm_pkg::NUM_PERIPH_REQ; r++) begin
      mb = 32'(32'h100 + rmap[r] * 16);
      setup(rmap[r], 16'h0001, mb, byte_cfg);
      do_xfer(r);
      chk(rda, mb, "route");
    end
    $display("test routing done");
    report_and_stop();
  end
endmodule
